// ==== core/embedded_ram_block.sv ====
`timescale 1ns/100ps

// Contract
// - ROM registers its address; output registered or direct, as configured.
// - ROM read behaves and times like a single-port RAM read.
// - FIFO storage read data is always unregistered.
// - Only the eight legal clock mode and memory mode pairings operate.
// - Independent mode: each port's registers run on that port's clock.
// - Independent mode: each port has its own enable and clear.
// - Input/output mode: inputs on one clock, output register on another.
// - Input/output mode: separate enables and clears for input and output groups.
// - Read/write mode: write clock takes write side, read clock takes read side.
// - Read/write mode: each clock has its own enable and clear.
// - Single-port mode hosts two independent single-port RAMs.
// - All inputs registered except the read address in pseudo-async read; write strobe is self-timed from the port clock.
// - Output registers can be bypassed.
// - Pseudo-async read: data within the cycle the address is presented.
// - Clears of input and output registers act in step with the clock.
// - Same-port read-during-write shows the new data in the write cycle.
// - Same-port read-during-write in true dual-port: masked bytes undefined.
// - Mixed-port collision returns old contents or undefined, as configured.
// - Mixed-port collision with different port clocks returns undefined.
// - Outside pseudo-async read, with read enable low the previous read value is held.
// - The array commits write data on the rising edge one cycle after the capture edge.
module embedded_ram_block #(
  parameter logic [7:0] UNDEF_BYTE = 8'hFF
) (
  // Clock and reset
  input  wire logic                                      clk_sys,
  input  wire logic                                      rst,
  // AHB-Lite slave
  input  wire logic                                      hsel,
  input  wire logic [31:0]                               haddr,
  input  wire logic [1:0]                                htrans,
  input  wire logic                                      hwrite,
  input  wire logic [2:0]                                hsize,
  input  wire logic [31:0]                               hwdata,
  input  wire logic                                      hready,
  output      logic                                      hreadyout,
  output      logic                                      hresp,
  output      logic [31:0]                               hrdata,
  // Memory ports, index 0 is port A
  input  wire ram_pkg::mem_req_t [ram_pkg::NPORT-1:0]    req,
  input  wire ram_pkg::clk_ctl_t [ram_pkg::NPORT-1:0]    ctl,
  output      logic [ram_pkg::NPORT-1:0][ram_pkg::DATA_W-1:0] q
);
  import ram_pkg::*;

  localparam int DEPTH = 2 ** ADDR_W;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] din;
    logic [BE_W-1:0]   be;
    logic              we;
    logic              rd;
    logic [DATA_W-1:0] lat;
    logic [DATA_W-1:0] q;
  } port_t;

  typedef struct packed {
    cfg_t               cfg;
    logic               coll;
    logic               rdw;
    logic               ahb_wr;
    logic [31:0]        ahb_addr;
    logic [31:0]        rdata;
    port_t [NPORT-1:0]  p;
  } state_t;

  state_t s;
  state_t next_s;
  logic [DATA_W-1:0] mem [DEPTH];
  logic              legal;
  logic [NPORT-1:0]  can_wr;
  logic [NPORT-1:0]  can_rd;
  logic [NPORT-1:0]  oreg;
  logic              pseudo_rd;

  ////////////////////////////////////////////////////////////////////////////

  // Array word with pending commits folded in
  function automatic logic [DATA_W-1:0] peek(input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] w;
    w = mem[a];
    for (int k = 0; k < NPORT; k++) begin
      if (s.p[k].we && s.p[k].addr == a) begin
        for (int b = 0; b < BE_W; b++) begin
          if (s.p[k].be[b]) begin
            w[b*BYTE_W +: BYTE_W] = s.p[k].din[b*BYTE_W +: BYTE_W];
          end
        end
      end
    end
    return w;
  endfunction

  function automatic logic mode_legal(input cfg_t c);
    logic ok;
    ok = 1'b0;
    unique case (c.clk_mode)
      CLK_INDEP: begin
        ok = (c.mem_mode == MEM_TRUE_DP);
      end
      CLK_IO: begin
        ok = (c.mem_mode == MEM_TRUE_DP) || (c.mem_mode == MEM_SIMPLE_DP) ||
             (c.mem_mode == MEM_FIFO);
      end
      CLK_RW: begin
        // FIFO storage sits on a simple dual-port array
        ok = (c.mem_mode == MEM_SIMPLE_DP) || (c.mem_mode == MEM_FIFO);
      end
      CLK_SINGLE: begin
        ok = (c.mem_mode == MEM_SINGLE) || (c.mem_mode == MEM_ROM);
      end
    endcase
    return ok;
  endfunction

  // Effective array address; single-port mode splits the array in halves
  function automatic logic [ADDR_W-1:0] eff_addr(input int i, input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] r;
    r = a;
    if (s.cfg.mem_mode == MEM_SINGLE) begin
      r = {i[0], a[ADDR_W-2:0]};
    end
    return r;
  endfunction

  // Register images; fields are placed by the package constants
  function automatic logic [31:0] ctrl_word(input cfg_t c);
    logic [31:0] w;
    w = 32'h0;
    w[CTRL_MEM_LSB +: 3]  = c.mem_mode;
    w[CTRL_CLK_LSB +: 2]  = c.clk_mode;
    w[CTRL_OREG_LSB +: 2] = c.out_reg;
    w[CTRL_OLD]           = c.old_data;
    w[CTRL_SAMECLK]       = c.same_clock;
    w[CTRL_PSEUDO]        = c.pseudo_async;
    return w;
  endfunction

  function automatic cfg_t word_ctrl(input logic [31:0] w);
    cfg_t c;
    c.mem_mode     = mem_mode_t'(w[CTRL_MEM_LSB +: 3]);
    c.clk_mode     = clk_mode_t'(w[CTRL_CLK_LSB +: 2]);
    c.out_reg      = w[CTRL_OREG_LSB +: 2];
    c.old_data     = w[CTRL_OLD];
    c.same_clock   = w[CTRL_SAMECLK];
    c.pseudo_async = w[CTRL_PSEUDO];
    return c;
  endfunction

  function automatic logic [31:0] status_word(input logic ok);
    logic [31:0] w;
    w = 32'h0;
    w[STAT_LEGAL] = ok;
    w[STAT_COLL]  = s.coll;
    w[STAT_RDW]   = s.rdw;
    for (int k = 0; k < NPORT; k++) begin
      w[STAT_WE_LSB + k] = s.p[k].we;
    end
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  // Port roles per memory mode
  always_comb begin
    legal  = mode_legal(s.cfg);
    can_wr = '0;
    can_rd = '0;
    unique case (s.cfg.mem_mode)
      MEM_TRUE_DP: begin
        can_wr = 2'h3;
        can_rd = 2'h3;
      end
      MEM_SIMPLE_DP, MEM_FIFO: begin
        can_wr = 2'h1;
        can_rd = 2'h2;
      end
      MEM_SINGLE: begin
        can_wr = 2'h3;
        can_rd = 2'h3;
      end
      MEM_ROM: begin
        can_wr = 2'h0;
        can_rd = 2'h1;
      end
      default: begin
        can_wr = 2'h0;
        can_rd = 2'h0;
      end
    endcase
    if (!legal) begin
      can_wr = '0;
      can_rd = '0;
    end
    // FIFO storage never uses the output register
    for (int i = 0; i < NPORT; i++) begin
      oreg[i] = s.cfg.out_reg[i] && (s.cfg.mem_mode != MEM_FIFO);
    end
    pseudo_rd = s.cfg.pseudo_async &&
                (s.cfg.mem_mode == MEM_TRUE_DP || s.cfg.mem_mode == MEM_SIMPLE_DP);
  end

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    logic              in_en;
    logic              out_en;
    logic              in_clr;
    logic              out_clr;
    logic [ADDR_W-1:0] ea;
    logic [ADDR_W-1:0] eo;
    logic [DATA_W-1:0] word;
    logic              hit;
    int                j;
    in_en   = 1'b0;
    out_en  = 1'b0;
    in_clr  = 1'b0;
    out_clr = 1'b0;
    ea      = '0;
    eo      = '0;
    word    = '0;
    hit     = 1'b0;
    j       = 0;
    next_s  = s;

    // Bus address phase
    next_s.ahb_wr = 1'b0;
    if (hsel && hready && htrans == HTRANS_NONSEQ) begin
      next_s.ahb_wr   = hwrite;
      next_s.ahb_addr = haddr;
      // Read data loads in the address phase, so no wait state is needed
      if (!hwrite) begin
        if (haddr == OFS_CTRL) begin
          next_s.rdata = ctrl_word(s.cfg);
        end else if (haddr == OFS_STATUS) begin
          next_s.rdata = status_word(legal);
        end else begin
          next_s.rdata = 32'h0;
        end
      end
    end

    // Bus data phase; collision and read-during-write status bits are write-one-to-clear
    if (s.ahb_wr) begin
      if (s.ahb_addr == OFS_CTRL) begin
        next_s.cfg = word_ctrl(hwdata);
      end else if (s.ahb_addr == OFS_STATUS) begin
        if (hwdata[STAT_COLL]) begin
          next_s.coll = 1'b0;
        end
        if (hwdata[STAT_RDW]) begin
          next_s.rdw = 1'b0;
        end
      end
    end

    // Per-port register groups
    for (int i = 0; i < NPORT; i++) begin
      j = 1 - i;
      // Independent, read/write and single-port modes run a port on one clock
      in_en  = ctl[i].ce_in;
      in_clr = ctl[i].clr_in;
      if (s.cfg.clk_mode == CLK_IO) begin
        out_en  = ctl[i].ce_out;
        out_clr = ctl[i].clr_out;
      end else begin
        out_en  = ctl[i].ce_in;
        out_clr = ctl[i].clr_in;
      end
      ea = eff_addr(i, req[i].addr);
      eo = eff_addr(j, req[j].addr);
      // A writer held in clear captures nothing, so it cannot collide
      hit = ctl[j].ce_in && !ctl[j].clr_in && req[j].wren && can_wr[j] && (eo == ea);

      // Self-timed strobe lasts one cycle after capture
      next_s.p[i].we = 1'b0;
      if (in_clr) begin
        next_s.p[i].addr = '0;
        next_s.p[i].din  = '0;
        next_s.p[i].be   = '0;
        next_s.p[i].rd   = 1'b0;
      end else if (in_en) begin
        next_s.p[i].addr = ea;
        next_s.p[i].din  = req[i].wdata;
        next_s.p[i].be   = req[i].be;
        next_s.p[i].we   = req[i].wren && can_wr[i];
        next_s.p[i].rd   = req[i].rden && can_rd[i];
        if (req[i].rden && can_rd[i]) begin
          word = peek(ea);
          if (req[i].wren && can_wr[i]) begin
            next_s.rdw = 1'b1;
            for (int b = 0; b < BE_W; b++) begin
              if (req[i].be[b]) begin
                word[b*BYTE_W +: BYTE_W] = req[i].wdata[b*BYTE_W +: BYTE_W];
              end else if (s.cfg.mem_mode == MEM_TRUE_DP) begin
                word[b*BYTE_W +: BYTE_W] = UNDEF_BYTE;
              end
            end
          end else if (hit) begin
            next_s.coll = 1'b1;
            // Old word is what the array holds until the next rising edge commit
            if (!s.cfg.same_clock) begin
              word = {BE_W{UNDEF_BYTE}};
            end else if (!s.cfg.old_data) begin
              word = {BE_W{UNDEF_BYTE}};
            end
          end
          next_s.p[i].lat = word;
        end
        // A capture with read enable low keeps the last read word
      end

      // Output register stage
      if (out_clr) begin
        next_s.p[i].q = '0;
      end else if (out_en) begin
        next_s.p[i].q = s.p[i].lat;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      // Comes up as a single-port RAM so the block is usable at once
      s     <= '0;
      s.cfg <= CFG_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Array has no reset; contents survive a block reset
  always_ff @(posedge clk_sys) begin
    for (int k = 0; k < NPORT; k++) begin
      if (s.p[k].we) begin
        for (int b = 0; b < BE_W; b++) begin
          if (s.p[k].be[b]) begin
            mem[s.p[k].addr][b*BYTE_W +: BYTE_W] <= s.p[k].din[b*BYTE_W +: BYTE_W];
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Read data selection, one multiplexer per port
  for (genvar g = 0; g < NPORT; g++) begin : g_rd
    always_comb begin
      if (pseudo_rd && can_rd[g]) begin
        // Trades the address register for same-cycle data
        q[g] = peek(eff_addr(g, req[g].addr));
      end else if (oreg[g]) begin
        q[g] = s.p[g].q;
      end else begin
        // Bypassed output shows the read latch directly
        q[g] = s.p[g].lat;
      end
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = HRESP_OKAY;
  assign hrdata    = s.rdata;

endmodule

// ==== core/ram_pkg.sv ====
package ram_pkg;

  // Geometry of the array
  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;
  localparam int BE_W   = 2;
  localparam int BYTE_W = 8;
  localparam int NPORT  = 2;

  // Register byte addresses
  localparam logic [31:0] OFS_CTRL   = 32'h0000_0000;
  localparam logic [31:0] OFS_STATUS = 32'h0000_0004;

  // Control field positions
  localparam int CTRL_MEM_LSB  = 0;
  localparam int CTRL_CLK_LSB  = 3;
  localparam int CTRL_OREG_LSB = 5;
  localparam int CTRL_OLD      = 7;
  localparam int CTRL_SAMECLK  = 8;
  localparam int CTRL_PSEUDO   = 9;

  // Status field positions
  localparam int STAT_LEGAL = 0;
  localparam int STAT_COLL  = 1;
  localparam int STAT_RDW   = 2;
  localparam int STAT_WE_LSB = 3;

  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

  typedef enum logic [2:0] {
    MEM_TRUE_DP, MEM_SIMPLE_DP, MEM_SINGLE, MEM_ROM, MEM_FIFO
  } mem_mode_t;

  typedef enum logic [1:0] {
    CLK_INDEP, CLK_IO, CLK_RW, CLK_SINGLE
  } clk_mode_t;

  typedef struct packed {
    mem_mode_t  mem_mode;
    clk_mode_t  clk_mode;
    logic [1:0] out_reg;
    logic       old_data;
    logic       same_clock;
    logic       pseudo_async;
  } cfg_t;

  localparam cfg_t CFG_RESET = '{mem_mode: MEM_SINGLE, clk_mode: CLK_SINGLE, out_reg: 2'h3,
                                 old_data: 1'b1, same_clock: 1'b1, pseudo_async: 1'b0};

  // User side request of one port
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [BE_W-1:0]   be;
    logic              wren;
    logic              rden;
  } mem_req_t;

  // Clock enables and clears of one port
  typedef struct packed {
    logic ce_in;
    logic ce_out;
    logic clr_in;
    logic clr_out;
  } clk_ctl_t;

endpackage

// ==== dv/embedded_ram_block_props.sv ====
`timescale 1ns/100ps

module embedded_ram_block_props
  import ram_pkg::*;
#(
  parameter logic [7:0] UNDEF_BYTE = 8'hFF
) (
  // Clock and reset
  input wire logic                                    clk_sys,
  input wire logic                                    rst,
  // Bus
  input wire logic                                    hsel,
  input wire logic [31:0]                             haddr,
  input wire logic [1:0]                              htrans,
  input wire logic                                    hwrite,
  input wire logic [31:0]                             hwdata,
  input wire logic                                    hready,
  // Memory ports
  input wire ram_pkg::mem_req_t [ram_pkg::NPORT-1:0]  req,
  input wire ram_pkg::clk_ctl_t [ram_pkg::NPORT-1:0]  ctl,
  input wire logic [ram_pkg::NPORT-1:0][ram_pkg::DATA_W-1:0] q
);
  logic       wr_ph;
  logic [9:0] cf;
  // Shadow of the control word, snooped off the bus
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_ph <= 1'b0;
      cf    <= 10'h1FA;
    end else begin
      if (hready) wr_ph <= hsel && htrans == HTRANS_NONSEQ && hwrite && haddr == OFS_CTRL;
      if (wr_ph) cf <= hwdata[9:0];
    end
  end
  wire cap0 = ctl[0].ce_in && !ctl[0].clr_in;
  wire cap1 = ctl[1].ce_in && !ctl[1].clr_in;
  wire sp   = cf[4:0] == 5'h1A && !cf[9];
  wire dp   = cf[4:0] == 5'h00 && !cf[9];
  wire io   = cf[4:3] == 2'h1 && cf[2:0] < 3'h2 && !cf[9];
  wire ok   = cf[4:0] inside {5'h00, 5'h08, 5'h09, 5'h11, 5'h1A};
  wire rdw0 = cap0 && req[0].wren && req[0].rden && req[0].be == 2'h3;
  wire mix  = cap0 && cap1 && req[0].wren && req[1].rden && !req[1].wren
              && req[0].addr == req[1].addr;
  ////////////////////////////////////////////////////////////
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Config must settle two edges, since the output source follows it
  chk_rd_hold:
    assert property (cf == $past(cf, 2) && !cf[9] && !cf[5] && !$past(cap0 && req[0].rden)
      |-> $stable(q[0])) else $error("port A output moved without a read");
  chk_rdw_new:
    assert property (sp && !cf[5] && rdw0 |=> q[0] == $past(req[0].wdata))
      else $error("same-port read missed new data");
  chk_rdw_reg:
    assert property (sp && cf[5] && rdw0 ##1 ctl[0].ce_in |=> q[0] == $past(req[0].wdata, 2))
      else $error("registered read wrong");
  chk_mix_undef:
    assert property (dp && !cf[6] && !(cf[7] && cf[8]) && mix |=> q[1] == {2{UNDEF_BYTE}})
      else $error("mixed collision not undefined");
  chk_ill_quiet:
    assert property (cf[2:0] < 3'h3 && !ok && !cf[9] && cf == $past(cf, 2) |=> $stable(q))
      else $error("illegal mode produced a read");
  chk_clr_out:
    assert property (io && cf[5] && ctl[0].clr_out && ctl[0].ce_out |=> q[0] == '0)
      else $error("output clear missed");
  chk_ceout_hold:
    assert property (io && cf[5] && !ctl[0].ce_out && !ctl[0].clr_out && cf == $past(cf)
      |=> $stable(q[0])) else $error("output group moved while disabled");
  chk_cein_hold:
    assert property (dp && !ctl[1].ce_in && !ctl[1].clr_in && cf == $past(cf)
      |=> $stable(q[1]))
      else $error("port B moved while disabled");
  cov_rdw: cover property (sp && rdw0);
  cov_mix: cover property (dp && mix);
  cov_clr: cover property (io && ctl[0].clr_out);
endmodule

bind embedded_ram_block embedded_ram_block_props #(.UNDEF_BYTE(UNDEF_BYTE)) u_props (
  .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .req(req), .ctl(ctl), .q(q));

// ==== dv/embedded_ram_clocking_rdw_tb.sv ====
`timescale 1ns/100ps

module embedded_ram_clocking_rdw_tb;
  import ram_pkg::*;
  localparam logic [7:0] UNDEF = 8'hFF;
  logic                         clk_sys;
  logic                         rst;
  logic                         hsel;
  logic                         hwrite;
  logic                         hreadyout;
  logic                         hresp;
  logic [1:0]                   htrans;
  logic [31:0]                  haddr;
  logic [31:0]                  hwdata;
  logic [31:0]                  hrdata;
  logic [31:0]                  rv;
  logic [NPORT-1:0][DATA_W-1:0] q;
  mem_req_t [NPORT-1:0]         req;
  clk_ctl_t [NPORT-1:0]         ctl;
  int                           failures;
  int                           n_checks;
  int                           mem [int];

  embedded_ram_block #(.UNDEF_BYTE(UNDEF)) uut (
    .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .req(req), .ctl(ctl), .q(q));
  user_logic pl (.clk_sys(clk_sys), .req(req), .ctl(ctl));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d, mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask
  task automatic cfg(input int m, input int c, input int o, input int od, input int sc,
                     input int ps);
    ahb(1'b1, OFS_CTRL, 32'(ps * 512 + sc * 256 + od * 128 + o * 32 + c * 8 + m));
  endtask
  function automatic mem_req_t mk(input int a, input int d, input int b, input int w,
                                  input int r);
    mk = '{addr: a[7:0], wdata: d[15:0], be: b[1:0], wren: w[0], rden: r[0]};
  endfunction
  task automatic op(input mem_req_t a, input mem_req_t b);
    pl.drive(a, b);
    pl.done();
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    #100000;
    failures++;
    summarize();
  end
  initial begin
    int a, d, e;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    failures = 0;
    n_checks = 0;
    rst = 1'b1;
    void'($urandom(32));
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    ahb(1'b0, OFS_CTRL, 0);
    check("ctrl reset", rv, 32'h1FA);
    ahb(1'b0, OFS_STATUS, 0);
    check("legal reset", rv[0], 1);
    check("hresp", hresp, HRESP_OKAY);
    check("q reset", q, 0);
    $display("test reset done");
    // Single-port: two independent halves, bypassed then registered output
    cfg(2, 3, 0, 1, 1, 0);
    for (int i = 0; i < 4; i++) begin
      a = $urandom_range(255);
      d = $urandom_range(16'hFFFF);
      op(mk(a, d, 3, 1, 1), mk(a, d ^ 'h5A5A, 3, 1, 0));
      mem[a % 128] = d;
      mem[128 + a % 128] = d ^ 'h5A5A;
      check("single rdw", q[0], d);
      op(mk(a, 0, 3, 0, 1), mk(a, 0, 3, 0, 1));
      check("single A", q[0], mem[a % 128]);
      check("single B", q[1], mem[128 + a % 128]);
      op(mk(a ^ 1, 0, 3, 0, 0), '0);
      check("hold", q[0], mem[a % 128]);
    end
    cfg(2, 3, 3, 1, 1, 0);
    op(mk(a, d ^ 'h0F0F, 3, 1, 1), '0);
    @(posedge clk_sys);
    #1;
    check("registered rdw", q[0], d ^ 'h0F0F);
    $display("test single done");
    // True dual-port, byte enables and collisions
    cfg(0, 0, 0, 1, 1, 0);
    d = $urandom_range(16'hFFFF);
    e = $urandom_range(16'hFFFF);
    op(mk(a, d, 3, 1, 0), '0);
    op(mk(a, e, 1, 1, 1), '0);
    check("masked rdw", q[0], {UNDEF, e[7:0]});
    mem[a] = (d & 'hFF00) | (e & 'hFF);
    for (int k = 0; k < 4; k++) begin
      cfg(0, 0, 0, k / 2, k % 2, 0);
      e = $urandom_range(16'hFFFF);
      op(mk(a, e, 3, 1, 0), mk(a, 0, 3, 0, 1));
      check("mixed rdw", q[1], (k == 3) ? mem[a] : {2{UNDEF}});
      mem[a] = e;
    end
    ahb(1'b0, OFS_STATUS, 0);
    check("coll seen", rv[1], 1);
    ahb(1'b1, OFS_STATUS, 32'h6);
    ahb(1'b0, OFS_STATUS, 0);
    check("flags cleared", rv[2:1], 0);
    cfg(0, 0, 0, 1, 1, 1);
    pl.drive(mk(a, 0, 3, 0, 1), '0);
    check("pseudo read", q[0], mem[a]);
    pl.done();
    $display("test dual done");
    for (int m = 0; m < 5; m++)
      for (int c = 0; c < 4; c++) begin
        cfg(m, c, 0, 1, 1, 0);
        ahb(1'b0, OFS_STATUS, 0);
        check("legal", rv[0], (m == 0 && c < 2) || (m == 1 && c inside {1, 2}) ||
              (m == 2 && c == 3) || (m == 3 && c == 3) || (m == 4 && c inside {1, 2}));
      end
    $display("test modes done");
    // Input/output clocking: output group gated and cleared apart
    cfg(0, 1, 3, 1, 1, 0);
    pl.set_ctl(0, 4'b1000);
    rv = q[0];
    e = $urandom_range(16'hFFFF);
    op(mk(a, e, 3, 1, 1), '0);
    mem[a] = e;
    @(posedge clk_sys);
    #1;
    check("out gated", q[0], rv[15:0]);
    pl.set_ctl(0, 4'b1100);
    @(posedge clk_sys);
    #1;
    check("out clocked", q[0], e);
    pl.set_ctl(0, 4'b1101);
    pl.set_ctl(0, 4'b1100);
    check("out clear", q[0], 0);
    // Independent clocking: port B enable
    cfg(0, 0, 0, 1, 1, 0);
    rv = q[1];
    pl.set_ctl(1, 4'b0100);
    op('0, mk(a, 0, 3, 0, 1));
    check("B gated", q[1], rv[15:0]);
    pl.set_ctl(1, 4'b1100);
    op('0, mk(a, 0, 3, 0, 1));
    check("B read", q[1], mem[a]);
    // FIFO storage on read/write clocking: output register asked for, never used
    cfg(4, 2, 3, 1, 1, 0);
    e = $urandom_range(16'hFFFF);
    op(mk(a, e, 3, 1, 0), '0);
    op('0, mk(a, 0, 3, 0, 1));
    check("fifo read", q[1], e);
    mem[a] = e;
    // ROM with registered output; a write attempt must not land
    cfg(3, 3, 1, 1, 1, 0);
    op(mk(a, e ^ 'hFFFF, 3, 1, 1), '0);
    @(posedge clk_sys);
    #1;
    check("rom read", q[0], mem[a]);
    $display("test clocking done");
    summarize();
  end
endmodule

// ==== dv/user_logic.sv ====
`timescale 1ns/100ps

module user_logic
  import ram_pkg::*;
(
  // Clock
  input  wire logic                              clk_sys,
  // Memory ports
  output      ram_pkg::mem_req_t [ram_pkg::NPORT-1:0] req,
  output      ram_pkg::clk_ctl_t [ram_pkg::NPORT-1:0] ctl
);
  initial begin
    req = '0;
    ctl = {2{4'b1100}};
  end
  // FIFO storage never sees a read and a write at once here
  task automatic drive(input mem_req_t a, input mem_req_t b);
    @(posedge clk_sys);
    req <= {b, a};
    #1;
  endtask
  // Addresses stay put across the capture edge
  task automatic done();
    @(posedge clk_sys);
    for (int i = 0; i < NPORT; i++) begin
      req[i].wren <= 1'b0;
      req[i].rden <= 1'b0;
    end
    #1;
  endtask
  task automatic set_ctl(input int p, input clk_ctl_t c);
    @(posedge clk_sys);
    ctl[p] <= c;
    #1;
  endtask
endmodule
